// file: design/cpu8_core.sv
// 8-bit accumulator core with its memory and an ahb-lite register slave
// Operation
// - rotate acc or memory through carry, set n z c; acc forms two cycles
// - memory zero test sets n z only from a direct-page byte; three cycles
// - nibble swap of acc sets n z; one byte, five cycles
// - immediate byte stored into direct page, no flags; three bytes, five cycles
// - acc store or load via x, then x plus one; four cycles
// - sp to x and x to sp, set n z; two cycles
// - swap x with y or acc, y with acc; four cycles, flags kept
// - y:a plus direct-page word, no carry in; n v h z c; five cycles
// - y:a minus direct-page word, no borrow in; n v h z c; five cycles
// - word compare sets n z c only; four cycles
// - direct-page word plus or minus one, set n z; six cycles
// - bit test: z from acc and mem, n from bit 7, v from bit 6
// - test acc against abs byte for n z, then clear or set in that byte the bits set in acc
// - carry and, or, xor with memory bit or its complement; and four cycles
// - branch on acc or dp bit clear or set; acc form four or six
// - flag branches two or four cycles; unconditional branch four
// - branch when acc differs from dp byte; five/seven, indexed six/eight
// - decrement dp byte or y, branch if nonzero; five/seven or four/six
// - break sets b, pushes pc high, low, status word; vector load; eight
// - interrupt disable clears i, enable sets i; three cycles
// - interrupt return pops status word, pc low, pc high; six cycles
// - halt stops processor and oscillator; one byte, three cycles
`timescale 1ns/1ps
module cpu8_core #(
  parameter int MEM_AW = 16
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // oscillator stop request
  output logic             osc_stop
);
  import cpu8_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} core_state_t;
  localparam int MEM_SIZE = 1 << MEM_AW;

  if (MEM_AW < 10 || MEM_AW > 16) begin : g_chk
    $error("MEM_AW must lie between 10 and 16");
  end

  logic [7:0]  mem [MEM_SIZE];
  core_state_t state_r;
  logic [3:0]  cnt_r;
  logic        run_r;
  logic        stop_r;
  logic [15:0] pc_r;
  logic [7:0]  a_r;
  logic [7:0]  x_r;
  logic [7:0]  y_r;
  logic [7:0]  sp_r;
  logic [7:0]  flags_r;
  logic [15:0] maddr_r;
  logic        dph_we_r;
  logic [7:0]  dph_ad_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;
  logic [15:0] pc_nxt;
  logic [7:0]  a_nxt;
  logic [7:0]  x_nxt;
  logic [7:0]  y_nxt;
  logic [7:0]  sp_nxt;
  logic [7:0]  flags_nxt;
  logic [3:0]  cyc_nxt;
  logic        halt_nxt;
  logic [2:0]  wr_en;
  logic [15:0] wr_ad [3];
  logic [7:0]  wr_dt [3];
  logic        addr_ph;
  logic        bus_wr;
  logic        idle_wr;

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign osc_stop  = stop_r;

  function automatic logic [7:0] rd(input logic [15:0] ad);
    return mem[ad[MEM_AW-1:0]];
  endfunction : rd

  ////////////////////////////////////////////////////////////////////////
  // decode and execute: all effects are computed in the fetch cycle
  always_comb begin
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  dpg;
    logic [15:0] ea_dp;
    logic [15:0] ea_dp1;
    logic [7:0]  m;
    logic [7:0]  r;
    logic [7:0]  rel;
    logic [8:0]  rr;
    logic [15:0] ya;
    logic [15:0] w;
    logic [15:0] rw;
    logic [16:0] s;
    logic [15:0] pcs;
    logic [15:0] jpc;
    logic [15:0] bad;
    logic [1:0]  len;
    logic        cf;
    logic        tk;
    logic        jmp;
    logic        bv;
    logic        snz;
    op = rd(pc_r);
    b1 = rd(pc_r + 16'h1);
    b2 = rd(pc_r + 16'h2);
    dpg = {7'h00, flags_r[F_G]};
    ea_dp = {dpg, b1};
    ea_dp1 = {dpg, b1 + 8'h01};
    m = 8'h00;
    r = 8'h00;
    rel = b1;
    rr = 9'h000;
    ya = {y_r, a_r};
    w = {rd(ea_dp1), rd(ea_dp)};
    rw = 16'h0000;
    s = 17'h00000;
    pcs = 16'h0000;
    jpc = 16'h0000;
    bad = {4'h0, b2[3:0], b1};
    len = 2'd1;
    cf = flags_r[F_C];
    tk = 1'b0;
    jmp = 1'b0;
    bv = 1'b0;
    snz = 1'b0;
    a_nxt = a_r;
    x_nxt = x_r;
    y_nxt = y_r;
    sp_nxt = sp_r;
    flags_nxt = flags_r;
    cyc_nxt = CY_OTHER;
    halt_nxt = 1'b0;
    wr_en = 3'b000;
    for (int i = 0; i < 3; i++) begin
      wr_ad[i] = 16'h0000;
      wr_dt[i] = 8'h00;
    end
    case (op)
      OP_ROL_A, OP_ROR_A: begin
        rr = op[6] ? {a_r[0], cf, a_r[7:1]} : {a_r, cf};
        r = rr[7:0];
        a_nxt = r;
        snz = 1'b1;
        flags_nxt[F_C] = rr[8];
        cyc_nxt = CY_ROT_A;
      end
      OP_ROL_DP, OP_ROR_DP, OP_ROL_DPX, OP_ROR_DPX, OP_ROL_ABS, OP_ROR_ABS: begin
        wr_ad[0] = !op[4] ? ea_dp : (op[0] ? {dpg, b1 + x_r} : {b2, b1});
        m = rd(wr_ad[0]);
        rr = op[6] ? {m[0], cf, m[7:1]} : {m, cf};
        r = rr[7:0];
        wr_en[0] = 1'b1;
        wr_dt[0] = r;
        snz = 1'b1;
        flags_nxt[F_C] = rr[8];
        len = (op[4] && !op[0]) ? 2'd3 : 2'd2;
        cyc_nxt = op[4] ? CY_ROT_IX : CY_ROT_DP;
      end
      OP_ZERO_TEST: begin
        r = rd(ea_dp);
        snz = 1'b1;
        len = 2'd2;
        cyc_nxt = CY_ZTEST;
      end
      OP_NIBBLE_SWAP: begin
        r = {a_r[3:0], a_r[7:4]};
        a_nxt = r;
        snz = 1'b1;
        cyc_nxt = CY_NSWAP;
      end
      OP_IMM_TO_MEM: begin
        wr_en[0] = 1'b1;
        wr_ad[0] = ea_dp;
        wr_dt[0] = b2;
        len = 2'd3;
        cyc_nxt = CY_IMM_MEM;
      end
      OP_STORE_XINC: begin
        wr_en[0] = 1'b1;
        wr_ad[0] = {dpg, x_r};
        wr_dt[0] = a_r;
        x_nxt = x_r + 8'h01;
        cyc_nxt = CY_XINC;
      end
      OP_LOAD_XINC: begin
        r = rd({dpg, x_r});
        a_nxt = r;
        snz = 1'b1;
        x_nxt = x_r + 8'h01;
        cyc_nxt = CY_XINC;
      end
      OP_SP_TO_X, OP_X_TO_SP: begin
        r = op[5] ? sp_r : x_r;
        if (op[5]) x_nxt = r;
        else sp_nxt = r;
        snz = 1'b1;
        cyc_nxt = CY_SP_MOV;
      end
      OP_X_Y_EXCH, OP_X_ACC_EXCH, OP_Y_ACC_EXCH: begin
        if (op == OP_X_Y_EXCH) begin
          x_nxt = y_r;
          y_nxt = x_r;
        end else if (op == OP_X_ACC_EXCH) begin
          x_nxt = a_r;
          a_nxt = x_r;
        end else begin
          y_nxt = a_r;
          a_nxt = y_r;
        end
        cyc_nxt = CY_EXCH;
      end
      OP_WORD_ADD, OP_WORD_SUB, OP_WORD_CMP: begin
        s = (op != OP_WORD_ADD) ? {1'b0, ya} - {1'b0, w} : {1'b0, ya} + {1'b0, w};
        rw = s[15:0];
        flags_nxt[F_N] = rw[15];
        flags_nxt[F_Z] = (rw == 16'h0000);
        flags_nxt[F_C] = (op != OP_WORD_ADD) ? !s[16] : s[16];
        if (op == OP_WORD_CMP) begin
          cyc_nxt = CY_WCMP;
        end else begin
          {y_nxt, a_nxt} = rw;
          flags_nxt[F_V] = (op[5] ? (ya[15] != w[15]) : (ya[15] == w[15]))
                           && (rw[15] != ya[15]);
          flags_nxt[F_H] = op[5] ^ ya[12] ^ w[12] ^ rw[12];
          cyc_nxt = CY_WADD;
        end
        len = 2'd2;
      end
      OP_WORD_INC, OP_WORD_DEC: begin
        rw = op[5] ? w - 16'h0001 : w + 16'h0001;
        wr_en[1:0] = 2'b11;
        wr_ad[0] = ea_dp;
        wr_dt[0] = rw[7:0];
        wr_ad[1] = ea_dp1;
        wr_dt[1] = rw[15:8];
        flags_nxt[F_N] = rw[15];
        flags_nxt[F_Z] = (rw == 16'h0000);
        len = 2'd2;
        cyc_nxt = CY_WSTEP;
      end
      OP_BIT_TEST_DP, OP_BIT_TEST_ABS: begin
        m = op[4] ? rd({b2, b1}) : rd(ea_dp);
        flags_nxt[F_Z] = ((a_r & m) == 8'h00);
        flags_nxt[F_N] = m[7];
        flags_nxt[F_V] = m[6];
        len = op[4] ? 2'd3 : 2'd2;
        cyc_nxt = op[4] ? CY_BIT_ABS : CY_BIT_DP;
      end
      OP_TEST_CLR, OP_TEST_SET: begin
        m = rd({b2, b1});
        r = a_r - m;
        snz = 1'b1;
        wr_en[0] = 1'b1;
        wr_ad[0] = {b2, b1};
        wr_dt[0] = op[6] ? (m & ~a_r) : (m | a_r);
        len = 2'd3;
        cyc_nxt = CY_TBITS;
      end
      OP_CARRY_AND, OP_CARRY_OR, OP_CARRY_XOR: begin
        m = rd(bad);
        bv = m[b2[7:5]] ^ b2[4];
        if (op == OP_CARRY_AND) flags_nxt[F_C] = cf & bv;
        else if (op == OP_CARRY_OR) flags_nxt[F_C] = cf | bv;
        else flags_nxt[F_C] = cf ^ bv;
        len = 2'd3;
        cyc_nxt = (op == OP_CARRY_AND) ? CY_C_AND : CY_C_OTHER;
      end
      OP_BRANCH: begin
        tk = 1'b1;
        len = 2'd2;
        cyc_nxt = CY_BRA;
      end
      OP_CMP_BR, OP_CMP_BR_X: begin
        m = op[4] ? rd(ea_dp) : rd({dpg, b1 + x_r});
        tk = (a_r != m);
        rel = b2;
        len = 2'd3;
        cyc_nxt = (op[4] ? CY_CBR : CY_CBR_X) + (tk ? CY_TAKEN : 4'd0);
      end
      OP_DEC_BR: begin
        r = rd(ea_dp) - 8'h01;
        wr_en[0] = 1'b1;
        wr_ad[0] = ea_dp;
        wr_dt[0] = r;
        tk = (r != 8'h00);
        rel = b2;
        len = 2'd3;
        cyc_nxt = CY_DBR + (tk ? CY_TAKEN : 4'd0);
      end
      OP_DEC_BR_Y: begin
        y_nxt = y_r - 8'h01;
        tk = (y_nxt != 8'h00);
        len = 2'd2;
        cyc_nxt = CY_DBR_Y + (tk ? CY_TAKEN : 4'd0);
      end
      OP_SW_BREAK: begin
        pcs = pc_r + 16'h1;
        flags_nxt[F_B] = 1'b1;
        wr_en = 3'b111;
        wr_ad[0] = {STACK_PAGE, sp_r};
        wr_dt[0] = pcs[15:8];
        wr_ad[1] = {STACK_PAGE, sp_r - 8'h01};
        wr_dt[1] = pcs[7:0];
        wr_ad[2] = {STACK_PAGE, sp_r - 8'h02};
        wr_dt[2] = flags_nxt;
        flags_nxt[F_I] = 1'b0;
        sp_nxt = sp_r - 8'h03;
        jmp = 1'b1;
        jpc = {rd(BREAK_VEC + 16'h1), rd(BREAK_VEC)};
        cyc_nxt = CY_BREAK;
      end
      OP_INT_DIS, OP_INT_EN: begin
        flags_nxt[F_I] = op[7];
        cyc_nxt = CY_IEN;
      end
      OP_INT_RET: begin
        flags_nxt = rd({STACK_PAGE, sp_r + 8'h01});
        jpc = {rd({STACK_PAGE, sp_r + 8'h03}), rd({STACK_PAGE, sp_r + 8'h02})};
        sp_nxt = sp_r + 8'h03;
        jmp = 1'b1;
        cyc_nxt = CY_IRET;
      end
      OP_HALT: begin
        halt_nxt = 1'b1;
        cyc_nxt = CY_HALT;
      end
      default: begin
        if (op[3:0] == LO_BIT_BR_A || op[3:0] == LO_BIT_BR_DP) begin
          m = op[0] ? rd(ea_dp) : a_r;
          tk = m[op[7:5]] ^ op[4];
          rel = op[0] ? b2 : b1;
          len = op[0] ? 2'd3 : 2'd2;
          cyc_nxt = (op[0] ? CY_BB_DP : CY_BB_A) + (tk ? CY_TAKEN : 4'd0);
        end else if (op[3:0] == LO_FLAG_BR && op[4]) begin
          case (op[6:5])
            2'b00:   bv = flags_r[F_N];
            2'b01:   bv = flags_r[F_V];
            2'b10:   bv = flags_r[F_C];
            default: bv = flags_r[F_Z];
          endcase
          tk = (bv == op[7]);
          len = 2'd2;
          cyc_nxt = CY_FBR + (tk ? CY_TAKEN : 4'd0);
        end
      end
    endcase
    if (snz) begin
      flags_nxt[F_N] = r[7];
      flags_nxt[F_Z] = (r == 8'h00);
    end
    pcs = pc_r + {14'h0000, len};
    pc_nxt = jmp ? jpc : (tk ? pcs + {{8{rel[7]}}, rel} : pcs);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: one fetch cycle, then waits out the rest of the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (run_r) state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          cnt_r   <= cyc_nxt - 4'h1;
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt_r == 4'h1) state_r <= run_r ? ST_EXEC : ST_IDLE;
          else cnt_r <= cnt_r - 4'h1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // run and halt control; a halt wins over a same-cycle software start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r  <= 1'b0;
      stop_r <= 1'b0;
    end else if (state_r == ST_EXEC && halt_nxt) begin
      run_r  <= 1'b0;
      stop_r <= 1'b1;
    end else if (bus_wr && dph_ad_r == CTRL_OFS) begin
      run_r <= hwdata[0];
      if (hwdata[0]) stop_r <= 1'b0;
    end
  end

  // architectural registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r    <= PC_RST;
      a_r     <= 8'h00;
      x_r     <= 8'h00;
      y_r     <= 8'h00;
      sp_r    <= SP_RST;
      flags_r <= FLAGS_RST;
    end else if (state_r == ST_EXEC) begin
      pc_r    <= pc_nxt;
      a_r     <= a_nxt;
      x_r     <= x_nxt;
      y_r     <= y_nxt;
      sp_r    <= sp_nxt;
      flags_r <= flags_nxt;
    end else if (idle_wr) begin
      if (dph_ad_r == PC_OFS) pc_r <= hwdata[15:0];
      if (dph_ad_r == FLAGS_OFS) flags_r <= hwdata[7:0];
      if (dph_ad_r == REGS_OFS) {sp_r, y_r, x_r, a_r} <= hwdata;
    end
  end

  // memory: core writes while executing, bus writes only while idle
  always_ff @(posedge hclk) begin
    if (state_r == ST_EXEC) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en[i]) mem[wr_ad[i][MEM_AW-1:0]] <= wr_dt[i];
      end
    end else if (idle_wr && dph_ad_r == MDATA_OFS) begin
      mem[maddr_r[MEM_AW-1:0]] <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  assign addr_ph = hsel && htrans[1] && hready;
  assign bus_wr  = dph_we_r;
  assign idle_wr = dph_we_r && state_r == ST_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_we_r    <= 1'b0;
      dph_ad_r    <= 8'h00;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      dph_we_r    <= addr_ph && hwrite && hsize == 3'b010;
      dph_ad_r    <= haddr[7:0];
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // read data is latched at the address phase; a data read steps the pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
      maddr_r  <= 16'h0000;
    end else begin
      if (addr_ph && !hwrite) begin
        case (haddr[7:0])
          CTRL_OFS:  hrdata_r <= {31'h0, run_r};
          STAT_OFS:  hrdata_r <= {30'h0, stop_r, state_r != ST_IDLE};
          PC_OFS:    hrdata_r <= {16'h0000, pc_r};
          REGS_OFS:  hrdata_r <= {sp_r, y_r, x_r, a_r};
          FLAGS_OFS: hrdata_r <= {24'h000000, flags_r};
          MADDR_OFS: hrdata_r <= {16'h0000, maddr_r};
          MDATA_OFS: hrdata_r <= {24'h000000, rd(maddr_r)};
          default:   hrdata_r <= 32'h0000_0000;
        endcase
      end
      if (bus_wr && dph_ad_r == MADDR_OFS) begin
        maddr_r <= hwdata[15:0];
      end else if ((idle_wr && dph_ad_r == MDATA_OFS)
                   || (addr_ph && !hwrite && haddr[7:0] == MDATA_OFS)) begin
        maddr_r <= maddr_r + 16'h1;
      end
    end
  end

endmodule : cpu8_core

// file: pkg/cpu8_pkg.sv
// constants shared by the 8-bit accumulator core
package cpu8_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STAT_OFS   = 8'h04;
  localparam logic [7:0]  PC_OFS     = 8'h08;
  localparam logic [7:0]  REGS_OFS   = 8'h0c;
  localparam logic [7:0]  FLAGS_OFS  = 8'h10;
  localparam logic [7:0]  MADDR_OFS  = 8'h14;
  localparam logic [7:0]  MDATA_OFS  = 8'h18;

  // reset values and fixed addresses
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [7:0]  SP_RST     = 8'hff;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  STACK_PAGE = 8'h01;
  localparam logic [15:0] BREAK_VEC  = 16'hffde;

  // status word bit positions
  localparam int F_N = 7;
  localparam int F_V = 6;
  localparam int F_G = 5;
  localparam int F_B = 4;
  localparam int F_H = 3;
  localparam int F_I = 2;
  localparam int F_Z = 1;
  localparam int F_C = 0;

  // opcodes
  localparam logic [7:0] OP_ROL_A        = 8'h28;
  localparam logic [7:0] OP_ROL_DP       = 8'h29;
  localparam logic [7:0] OP_ROL_DPX      = 8'h39;
  localparam logic [7:0] OP_ROL_ABS      = 8'h38;
  localparam logic [7:0] OP_ROR_A        = 8'h68;
  localparam logic [7:0] OP_ROR_DP       = 8'h69;
  localparam logic [7:0] OP_ROR_DPX      = 8'h79;
  localparam logic [7:0] OP_ROR_ABS      = 8'h78;
  localparam logic [7:0] OP_ZERO_TEST    = 8'h4c;
  localparam logic [7:0] OP_NIBBLE_SWAP  = 8'hce;
  localparam logic [7:0] OP_IMM_TO_MEM   = 8'he4;
  localparam logic [7:0] OP_STORE_XINC   = 8'hfb;
  localparam logic [7:0] OP_LOAD_XINC    = 8'hdb;
  localparam logic [7:0] OP_SP_TO_X      = 8'hae;
  localparam logic [7:0] OP_X_TO_SP      = 8'h8e;
  localparam logic [7:0] OP_X_Y_EXCH     = 8'hfe;
  localparam logic [7:0] OP_X_ACC_EXCH   = 8'hee;
  localparam logic [7:0] OP_Y_ACC_EXCH   = 8'hde;
  localparam logic [7:0] OP_WORD_ADD     = 8'h1d;
  localparam logic [7:0] OP_WORD_SUB     = 8'h3d;
  localparam logic [7:0] OP_WORD_CMP     = 8'h5d;
  localparam logic [7:0] OP_WORD_INC     = 8'h9d;
  localparam logic [7:0] OP_WORD_DEC     = 8'hbd;
  localparam logic [7:0] OP_BIT_TEST_DP  = 8'h0c;
  localparam logic [7:0] OP_BIT_TEST_ABS = 8'h1c;
  localparam logic [7:0] OP_TEST_CLR     = 8'h5c;
  localparam logic [7:0] OP_TEST_SET     = 8'h3c;
  localparam logic [7:0] OP_CARRY_AND    = 8'h8b;
  localparam logic [7:0] OP_CARRY_OR     = 8'h6b;
  localparam logic [7:0] OP_CARRY_XOR    = 8'hab;
  localparam logic [7:0] OP_BRANCH       = 8'h2f;
  localparam logic [7:0] OP_CMP_BR       = 8'hfd;
  localparam logic [7:0] OP_CMP_BR_X     = 8'h8d;
  localparam logic [7:0] OP_DEC_BR       = 8'hac;
  localparam logic [7:0] OP_DEC_BR_Y     = 8'h7b;
  localparam logic [7:0] OP_SW_BREAK     = 8'h0f;
  localparam logic [7:0] OP_INT_DIS      = 8'h60;
  localparam logic [7:0] OP_INT_EN       = 8'he0;
  localparam logic [7:0] OP_INT_RET      = 8'h7f;
  localparam logic [7:0] OP_HALT         = 8'hef;
  localparam logic [3:0] LO_BIT_BR_A     = 4'h2;
  localparam logic [3:0] LO_BIT_BR_DP    = 4'h3;
  localparam logic [3:0] LO_FLAG_BR      = 4'h0;

  // cycle counts from opcode fetch
  localparam logic [3:0] CY_ROT_A   = 4'd2;
  localparam logic [3:0] CY_ROT_DP  = 4'd4;
  localparam logic [3:0] CY_ROT_IX  = 4'd5;
  localparam logic [3:0] CY_ZTEST   = 4'd3;
  localparam logic [3:0] CY_NSWAP   = 4'd5;
  localparam logic [3:0] CY_IMM_MEM = 4'd5;
  localparam logic [3:0] CY_XINC    = 4'd4;
  localparam logic [3:0] CY_SP_MOV  = 4'd2;
  localparam logic [3:0] CY_EXCH    = 4'd4;
  localparam logic [3:0] CY_WADD    = 4'd5;
  localparam logic [3:0] CY_WCMP    = 4'd4;
  localparam logic [3:0] CY_WSTEP   = 4'd6;
  localparam logic [3:0] CY_BIT_DP  = 4'd4;
  localparam logic [3:0] CY_BIT_ABS = 4'd5;
  localparam logic [3:0] CY_TBITS   = 4'd6;
  localparam logic [3:0] CY_C_AND   = 4'd4;
  localparam logic [3:0] CY_C_OTHER = 4'd5;
  localparam logic [3:0] CY_BB_A    = 4'd4;
  localparam logic [3:0] CY_BB_DP   = 4'd5;
  localparam logic [3:0] CY_FBR     = 4'd2;
  localparam logic [3:0] CY_BRA     = 4'd4;
  localparam logic [3:0] CY_CBR     = 4'd5;
  localparam logic [3:0] CY_CBR_X   = 4'd6;
  localparam logic [3:0] CY_DBR     = 4'd5;
  localparam logic [3:0] CY_DBR_Y   = 4'd4;
  localparam logic [3:0] CY_TAKEN   = 4'd2;
  localparam logic [3:0] CY_BREAK   = 4'd8;
  localparam logic [3:0] CY_IEN     = 4'd3;
  localparam logic [3:0] CY_IRET    = 4'd6;
  localparam logic [3:0] CY_HALT    = 4'd3;
  localparam logic [3:0] CY_OTHER   = 4'd2;

endpackage : cpu8_pkg

// file: tb/ahb_master_model.sv
// bus master standing in for software on the register slave
`timescale 1ns/1ps
module ahb_master_model (
  // clock and bus return
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0;
  end
  // one single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : ahb_master_model

// file: tb/cpu8_core_chk_sva.sv
// port checker for the accumulator core
`timescale 1ns/1ps
module cpu8_core_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        osc_stop
);
  import cpu8_pkg::*;
  logic       take;
  logic       rd_r;
  logic       wr_r;
  logic [7:0] ofs_r;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      ofs_r <= 8'h00;
    end else begin
      rd_r  <= take && !hwrite;
      wr_r  <= take && hwrite;
      ofs_r <= haddr[7:0];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout)
    else $error("wait state seen");
  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
  chk_rdata_held: assert property (!rd_r |-> $stable(hrdata))
    else $error("read data moved without a read");
  chk_stat_bits: assert property (rd_r && ofs_r == STAT_OFS |-> hrdata[31:2] == 30'h0
    && hrdata[1] == $past(osc_stop) && !(hrdata[1] && hrdata[0]))
    else $error("status word wrong");
  chk_stop_clear: assert property ($fell(osc_stop)
    |-> $past(wr_r && ofs_r == CTRL_OFS && hwdata[0]))
    else $error("stop released without a run write");
  chk_stop_holds: assert property (osc_stop && !(wr_r && ofs_r == CTRL_OFS && hwdata[0])
    |=> osc_stop)
    else $error("stop dropped by itself");
  chk_unmapped_zero: assert property (rd_r && ofs_r >= 8'h1c |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_halt_run_low: assert property (rd_r && ofs_r == CTRL_OFS && $past(osc_stop)
    |-> hrdata == 32'h0)
    else $error("run bit set while stopped");
endmodule : cpu8_core_chk

bind cpu8_core cpu8_core_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .osc_stop);

// file: tb/cpu8_instruction_execution_tb_top.sv
// self-checking bench for the accumulator core
`timescale 1ns/1ps
module cpu8_instruction_execution_tb_top;
  import cpu8_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_stop;
  int          n_errors = 0;
  int          comparisons = 0;
  int          base;
  // program, dp word, regs in, flags in, regs out, flags out, dp word out, cycles
  logic [151:0] rows [29] = '{
    152'h000000ef_0000_ff000000_00_ff000000_00_0000_00,
    152'h0000ef28_0000_ff000081_00_ff000002_01_0000_02,
    152'h0000ef68_0000_ff000001_01_ff000080_81_0000_02,
    152'h0000efce_0000_ff00003c_02_ff0000c3_80_0000_05,
    152'h00ef404c_0000_ff000000_81_ff000000_03_0000_03,
    152'hef5a40e4_0000_ff000000_c3_ff000000_c3_005a_05,
    152'h0000effb_0000_ff004077_00_ff004177_00_0077_04,
    152'h0000efdb_8000_ff004100_00_ff004280_80_8000_04,
    152'h0000efae_0000_00000511_00_00000011_02_0000_02,
    152'h0000ef8e_0000_ff009000_00_90009000_80_0000_02,
    152'h0000effe_0000_ff123456_cb_ff341256_cb_0000_04,
    152'h00ef401d_0001_ffff00ff_00_ff000000_0b_0001_05,
    152'h00ef403d_0001_ff000000_01_ffff00ff_80_0001_05,
    152'h00ef405d_1234_ff120034_40_ff120034_43_1234_04,
    152'h00ef409d_00ff_ff000000_02_ff000000_00_0100_06,
    152'h00ef40bd_0001_ff000000_00_ff000000_02_0000_06,
    152'h00ef400c_00c0_ff00000f_00_ff00000f_c2_00c0_04,
    152'hef00405c_003f_ff00000f_00_ff00000f_80_0030_06,
    152'hef00403c_0030_ff00000f_02_ff00000f_80_003f_06,
    152'heff0408b_0080_ff000000_01_ff000000_00_0080_04,
    152'h0000ef60_0000_ff000000_04_ff000000_00_0000_03,
    152'h0000efe0_0000_ff000000_00_ff000000_04_0000_03,
    152'h00ef0050_0000_ff000000_00_ff000000_00_0000_04,
    152'h00ef00f0_0000_ff000000_00_ff000000_00_0000_02,
    152'h00ef002f_0000_ff000000_00_ff000000_00_0000_04,
    152'h00ef0012_0000_ff000000_00_ff000000_00_0000_06,
    152'hef0040fd_0022_ff000011_00_ff000011_00_0022_07,
    152'h00ef007b_0000_ff020000_00_ff010000_00_0000_06,
    152'h0000ef0f_0000_ff000000_04_ff000000_14_0000_0e
  };
  assign hready = hreadyout;
  cpu8_core #(.MEM_AW(16)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .osc_stop);
  ahb_master_model bus (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  ////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  // start the core and count cycles until it stops itself
  task automatic run(output int c);
    wr(CTRL_OFS, 32'h1);
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (osc_stop !== 1'b1 && c < 400);
    @(posedge hclk);
  endtask : run
  task automatic do_row(input logic [151:0] r, output int c);
    wr(MADDR_OFS, 32'h40);
    wr(MDATA_OFS, {24'h0, r[111:104]});
    wr(MDATA_OFS, {24'h0, r[119:112]});
    wr(MADDR_OFS, 32'h200);
    for (int i = 0; i < 4; i++) wr(MDATA_OFS, {24'h0, r[120+8*i +: 8]});
    wr(PC_OFS, 32'h200);
    wr(REGS_OFS, r[103:72]);
    wr(FLAGS_OFS, {24'h0, r[71:64]});
    run(c);
    rd(REGS_OFS, r[63:32]);
    rd(FLAGS_OFS, {24'h0, r[31:24]});
    wr(MADDR_OFS, 32'h40);
    rd(MDATA_OFS, {24'h0, r[15:8]});
    rd(MDATA_OFS, {24'h0, r[23:16]});
  endtask : do_row
  ////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin : main
    int c;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // break vector to a return at 0300
    wr(MADDR_OFS, 32'hffde);
    wr(MDATA_OFS, 32'h00);
    wr(MDATA_OFS, 32'h03);
    wr(MADDR_OFS, 32'h300);
    wr(MDATA_OFS, 32'h7f);
    foreach (rows[i]) begin
      do_row(rows[i], c);
      if (i == 0) base = c;
      else chk(32'(c - base), {24'h0, rows[i][7:0]});
    end
    rd(STAT_OFS, 32'h2);
    rd(CTRL_OFS, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    // reset just after a run start, before the core leaves idle
    wr(REGS_OFS, 32'h12345678);
    wr(CTRL_OFS, 32'h1);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk({31'h0, osc_stop}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REGS_OFS, {SP_RST, 24'h0});
    rd(FLAGS_OFS, {24'h0, FLAGS_RST});
    rd(PC_OFS, {16'h0, PC_RST});
    rd(STAT_OFS, 32'h0);
    results();
  end
endmodule : cpu8_instruction_execution_tb_top
